// ===== pkg/enc_card_defs.svh
`ifndef ENC_CARD_DEFS_SVH
`define ENC_CARD_DEFS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS   25
`define BLINK_HALF_MS   500
`define ENC_STD_KHZ     200
`define ENC_FAST_KHZ    400

// ==========================================================
// Register offsets (byte addresses)
`define ADDR_W          8
`define REG_CTRL        8'h00
`define REG_DIV_PRI     8'h04
`define REG_DIV_ALT     8'h08
`define REG_DIV_ACT     8'h0c
`define REG_STATUS      8'h10
`define REG_MASK        8'h14
`define REG_ENC_POS     8'h18
`define REG_REF_POS     8'h1c

// ==========================================================
// Field positions and reset values
`define CTRL_LINK_LSB   0
`define CTRL_VAR_LSB    2
`define DIV_RESET       8'h01
`define STS_ENC_IDX     0
`define STS_REF_IDX     1
`define STS_WIRE_BRK    2
`define STS_OVERSPEED   3
`define BREAK_RUN       3'h3

`endif

// ===== pkg/enc_card_pkg.sv
`include "enc_card_defs.svh"

package enc_card_pkg;

	// Link state as written by the control side; Gray along off, establishing, up
	typedef enum logic [1:0] {
		LINK_OFF = 2'b00,
		LINK_EST = 2'b01,
		LINK_UP  = 2'b11,
		LINK_RSV = 2'b10
	} link_state_t;

	// Card variant, selects indicator style and encoder capture rate
	typedef enum logic [1:0] {
		VAR_FULL24      = 2'b00,
		VAR_SIMPLE24    = 2'b01,
		VAR_SIMPLE_FAST = 2'b11,
		VAR_RSV         = 2'b10
	} variant_t;

	typedef struct packed {
		link_state_t link;
		variant_t    variant;
		logic [7:0]  div_pri;
		logic [7:0]  div_alt;
		logic [7:0]  div_ratio;
		logic [7:0]  div_cnt;
		logic [1:0]  out_cnt;
		logic        out_idx;
		logic [3:0]  sts;
		logic [3:0]  mask;
		logic [31:0] rdata;
		logic [15:0] enc_pos;
		logic [15:0] ref_pos;
		logic [24:0] blink_cnt;
		logic        blink;
		logic        last_a;
		logic [2:0]  run;
		logic        lost;
		logic [6:0]  enc_gap;
		logic [6:0]  ref_gap;
		logic        led_link;
		logic        led_wire;
		logic        led_pwr;
	} core_state_t;

endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/100ps

module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_srst,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level,
	output logic      [W-1:0] o_change
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] chg;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	// ==========================================================
	// Three stages; the level moves only once stages two and three agree
	always_comb begin
		d     = q;
		d.s1  = i_pin;
		d.s2  = q.s1;
		d.s3  = q.s2;
		// Stages in disagreement hold the old level, so a one-cycle glitch never moves it
		d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
		d.chg = d.lvl ^ q.lvl;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_level  = q.lvl;
	assign o_change = q.chg;

	// Filtered level must follow a settled pair of stages
	property p_settled;
		@(posedge i_core_clk) disable iff (i_srst)
		(q.s2 == q.s3) |=> (q.lvl == $past(q.s3));
	endproperty
	a_settled: assert property (p_settled) else $error("sync level missed settled input");

endmodule // pin_sync

// ===== hdl/enc_card_top.sv
`timescale 1ns/100ps
`include "enc_card_defs.svh"

module enc_card_top
	import enc_card_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_MS * 1000000 / `CLK_PERIOD_NS
) (
	input  wire logic                 i_core_clk,
	input  wire logic                 i_srst,
	input  wire logic                 i_enc_phase_a,
	input  wire logic                 i_enc_phase_b,
	input  wire logic                 i_enc_index,
	input  wire logic                 i_ref_phase_a,
	input  wire logic                 i_ref_phase_b,
	input  wire logic                 i_ref_index,
	input  wire logic                 i_board_power,
	input  wire logic [`ADDR_W-1:0]   i_addr,
	input  wire logic [31:0]          i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [31:0]          o_rdata,
	output logic                      o_irq,
	output logic                      o_div_out_a,
	output logic                      o_div_out_b,
	output logic                      o_div_out_index,
	output logic                      o_link_state_led,
	output logic                      o_wire_break_led,
	output logic                      o_power_led
);

	localparam logic [6:0]  GAP_STD  = 7'(1000000 / (4 * `ENC_STD_KHZ * `CLK_PERIOD_NS));
	localparam logic [6:0]  GAP_FAST = 7'(1000000 / (4 * `ENC_FAST_KHZ * `CLK_PERIOD_NS));
	localparam logic [24:0] BLINK_LAST = 25'(BLINK_HALF_CYC - 1);

	core_state_t q;
	core_state_t d;
	logic [2:0]  enc_lvl;
	logic [2:0]  enc_chg;
	logic [2:0]  ref_lvl;
	logic [2:0]  ref_chg;
	logic        pwr_lvl;

	// ==========================================================
	// Pin capture
	pin_sync #(.W(3)) u_enc_sync (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.i_pin      ({i_enc_index, i_enc_phase_b, i_enc_phase_a}),
		.o_level    (enc_lvl),
		.o_change   (enc_chg)
	);

	// Reference set shares the encoder's signal type, so same capture path
	pin_sync #(.W(3)) u_ref_sync (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.i_pin      ({i_ref_index, i_ref_phase_b, i_ref_phase_a}),
		.o_level    (ref_lvl),
		.o_change   (ref_chg)
	);

	pin_sync #(.W(1)) u_pwr_sync (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.i_pin      (i_board_power),
		.o_level    (pwr_lvl),
		.o_change   ()
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic       a_step;
		logic       b_step;
		logic       e_step;
		logic       e_up;
		logic       r_step;
		logic       r_up;
		logic [6:0] gap_min;
		logic [3:0] ev;
		logic [3:0] clr;
		logic [7:0] wr_ratio;
		a_step   = enc_chg[0] & ~enc_chg[1];
		b_step   = enc_chg[1] & ~enc_chg[0];
		e_step   = a_step | b_step;
		// A edge with A != B means A leads
		e_up     = a_step ? (enc_lvl[0] ^ enc_lvl[1]) : ~(enc_lvl[0] ^ enc_lvl[1]);
		r_step   = ref_chg[0] ^ ref_chg[1];
		r_up     = ref_chg[0] ? (ref_lvl[0] ^ ref_lvl[1]) : ~(ref_lvl[0] ^ ref_lvl[1]);
		gap_min  = (q.variant == VAR_SIMPLE_FAST) ? GAP_FAST : GAP_STD;
		ev       = 4'h0;
		clr      = 4'h0;
		wr_ratio = (i_wdata[7:0] == 8'h00) ? `DIV_RESET : i_wdata[7:0];
		d        = q;
		d.rdata  = 32'h0;

		// Encoder position and edge spacing; steps closer than the rated rate are flagged
		if (e_step) begin
			d.enc_pos = e_up ? q.enc_pos + 16'h0001 : q.enc_pos - 16'h0001;
			d.enc_gap = 7'h00;
			ev[`STS_OVERSPEED] = (q.enc_gap < gap_min);
		end else if (q.enc_gap != 7'h7f) begin
			d.enc_gap = q.enc_gap + 7'h01;
		end

		// Reference position; both phases at once is illegal and dropped
		if (r_step) begin
			d.ref_pos = r_up ? q.ref_pos + 16'h0001 : q.ref_pos - 16'h0001;
			d.ref_gap = 7'h00;
			if (q.ref_gap < GAP_STD) begin
				ev[`STS_OVERSPEED] = 1'b1;
			end
		end else if (q.ref_gap != 7'h7f) begin
			d.ref_gap = q.ref_gap + 7'h01;
		end

		// Divider: one output quadrature step per ratio input steps
		if (e_step) begin
			if (q.div_cnt >= q.div_ratio - 8'h01) begin
				d.div_cnt = 8'h00;
				d.out_cnt = e_up ? q.out_cnt + 2'h1 : q.out_cnt - 2'h1;
			end else begin
				d.div_cnt = q.div_cnt + 8'h01;
			end
		end
		d.out_idx = enc_lvl[2];

		// Repeated edges on one phase with none on the other mean the other is lost
		if (a_step) begin
			d.run    = (q.last_a) ? ((q.run == 3'h7) ? q.run : q.run + 3'h1) : 3'h1;
			d.last_a = 1'b1;
		end else if (b_step) begin
			d.run    = (!q.last_a) ? ((q.run == 3'h7) ? q.run : q.run + 3'h1) : 3'h1;
			d.last_a = 1'b0;
		end
		d.lost = (d.run >= `BREAK_RUN);
		ev[`STS_WIRE_BRK] = d.lost & ~q.lost;
		ev[`STS_ENC_IDX]  = enc_chg[2] & enc_lvl[2];
		ev[`STS_REF_IDX]  = ref_chg[2] & ref_lvl[2];

		// Half-second tick shared by both blinking indicators
		if (q.blink_cnt == BLINK_LAST) begin
			d.blink_cnt = 25'h0;
			d.blink     = ~q.blink;
		end else begin
			d.blink_cnt = q.blink_cnt + 25'h1;
		end

		// Register writes; a new link state restarts the blink lit
		if (i_wr) begin
			if (i_addr == `REG_CTRL) begin
				d.link    = link_state_t'(i_wdata[`CTRL_LINK_LSB +: 2]);
				d.variant = variant_t'(i_wdata[`CTRL_VAR_LSB +: 2]);
				if (d.link != q.link) begin
					d.blink_cnt = 25'h0;
					d.blink     = 1'b1;
				end
			end else if (i_addr == `REG_DIV_PRI) begin
				d.div_pri   = i_wdata[7:0];
				d.div_ratio = wr_ratio;
				d.div_cnt   = 8'h00;
			end else if (i_addr == `REG_DIV_ALT) begin
				d.div_alt   = i_wdata[7:0];
				d.div_ratio = wr_ratio;
				d.div_cnt   = 8'h00;
			end else if (i_addr == `REG_STATUS) begin
				clr = i_wdata[3:0];
			end else if (i_addr == `REG_MASK) begin
				d.mask = i_wdata[3:0];
			end
		end

		// Set beats clear so an event in the clearing cycle survives
		d.sts = (q.sts & ~clr) | ev;

		// Reads answer one cycle later; unmapped offsets read zero
		if (i_rd) begin
			if (i_addr == `REG_CTRL) begin
				d.rdata = {28'h0, q.variant, q.link};
			end else if (i_addr == `REG_DIV_PRI) begin
				d.rdata = {24'h0, q.div_pri};
			end else if (i_addr == `REG_DIV_ALT) begin
				d.rdata = {24'h0, q.div_alt};
			end else if (i_addr == `REG_DIV_ACT) begin
				d.rdata = {24'h0, q.div_ratio};
			end else if (i_addr == `REG_STATUS) begin
				d.rdata = {28'h0, q.sts};
			end else if (i_addr == `REG_MASK) begin
				d.rdata = {28'h0, q.mask};
			end else if (i_addr == `REG_ENC_POS) begin
				d.rdata = {16'h0, q.enc_pos};
			end else if (i_addr == `REG_REF_POS) begin
				d.rdata = {16'h0, q.ref_pos};
			end
		end

		// Indicators
		case (q.link)
			LINK_EST: d.led_link = 1'b1;
			LINK_UP:  d.led_link = q.blink;
			default:  d.led_link = 1'b0;
		endcase
		if (q.variant == VAR_FULL24) begin
			d.led_wire = q.lost ? q.blink : 1'b1;
		end else begin
			d.led_wire = ~q.lost;
		end
		d.led_pwr = pwr_lvl;
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			q           <= '0;
			q.div_pri   <= `DIV_RESET;
			q.div_alt   <= `DIV_RESET;
			q.div_ratio <= `DIV_RESET;
		end else begin
			q <= d;
		end
	end

	// Output phases follow a 2-bit Gray count: 00, 10, 11, 01 when counting up
	assign o_div_out_a      = q.out_cnt[1] ^ q.out_cnt[0];
	assign o_div_out_b      = q.out_cnt[1];
	assign o_div_out_index  = q.out_idx;
	assign o_rdata          = q.rdata;
	assign o_irq            = |(q.sts & q.mask);
	assign o_link_state_led = q.led_link;
	assign o_wire_break_led = q.led_wire;
	assign o_power_led      = q.led_pwr;

	// ==========================================================
	// Checks
	sequence s_div_wrap;
		(enc_chg[0] ^ enc_chg[1]) && (q.div_cnt >= q.div_ratio - 8'h01);
	endsequence

	sequence s_out_moved;
		##1 (q.out_cnt != $past(q.out_cnt)) && (q.div_cnt == 8'h00);
	endsequence

	property p_link_est;
		@(posedge i_core_clk) disable iff (i_srst)
		(q.link == LINK_EST) [*2] |-> o_link_state_led;
	endproperty
	a_link_est: assert property (p_link_est) else $error("link led not lit while establishing");

	property p_link_blink;
		@(posedge i_core_clk) disable iff (i_srst)
		(q.link == LINK_UP) && $stable(q.link) && (q.blink_cnt == BLINK_LAST)
			&& !(i_wr && (i_addr == `REG_CTRL)) // A link write restarts the blink lit
			|=> ##1 (o_link_state_led != $past(o_link_state_led, 1));
	endproperty
	a_link_blink: assert property (p_link_blink) else $error("link led did not toggle");

	property p_link_off;
		@(posedge i_core_clk) disable iff (i_srst)
		(q.link == LINK_OFF) |=> !o_link_state_led;
	endproperty
	a_link_off: assert property (p_link_off) else $error("link led lit while disconnected");

	property p_wire_full;
		@(posedge i_core_clk) disable iff (i_srst)
		(q.variant == VAR_FULL24) |=> (o_wire_break_led == ($past(q.lost) ? $past(q.blink) : 1'b1));
	endproperty
	a_wire_full: assert property (p_wire_full) else $error("full variant wire led wrong");

	property p_wire_simple;
		@(posedge i_core_clk) disable iff (i_srst)
		(q.variant != VAR_FULL24) && q.lost |=> !o_wire_break_led;
	endproperty
	a_wire_simple: assert property (p_wire_simple) else $error("simplified wire led lit on loss");

	property p_power;
		@(posedge i_core_clk) disable iff (i_srst)
		(i_board_power [*5]) |-> ##1 o_power_led;
	endproperty
	a_power: assert property (p_power) else $error("power led dark with power present");

	property p_divide;
		@(posedge i_core_clk) disable iff (i_srst)
		s_div_wrap and !i_wr |-> s_out_moved;
	endproperty
	a_divide: assert property (p_divide) else $error("divider did not step output");

	property p_ratio_alt;
		@(posedge i_core_clk) disable iff (i_srst)
		i_wr && (i_addr == `REG_DIV_ALT) && (i_wdata[7:0] != 8'h00)
			|=> (q.div_ratio == $past(i_wdata[7:0]));
	endproperty
	a_ratio_alt: assert property (p_ratio_alt) else $error("alternate ratio not taken");

	property p_quad_up;
		@(posedge i_core_clk) disable iff (i_srst)
		enc_chg[0] && !enc_chg[1] && (enc_lvl[0] != enc_lvl[1])
			|=> (q.enc_pos == $past(q.enc_pos) + 16'h0001);
	endproperty
	a_quad_up: assert property (p_quad_up) else $error("leading A did not count up");

	property p_sts_sticky;
		@(posedge i_core_clk) disable iff (i_srst)
		q.sts[`STS_ENC_IDX] && !(i_wr && (i_addr == `REG_STATUS) && i_wdata[`STS_ENC_IDX])
			|=> q.sts[`STS_ENC_IDX];
	endproperty
	a_sts_sticky: assert property (p_sts_sticky) else $error("status bit lost without clear");

endmodule // enc_card_top

// ===== testbench/enc_src_model.sv
`timescale 1ns/100ps

module enc_src_model (
	input  wire logic i_core_clk,
	output logic      o_phase_a,
	output logic      o_phase_b,
	output logic      o_index
);
	// ==========================================================
	// Shaft state
	int phase_step;

	// Shaft at rest with every line low
	initial begin
		phase_step = 0;
		o_phase_a = 1'b0;
		o_phase_b = 1'b0;
		o_index = 1'b0;
	end

	// One quadrature step, A leads B going forward; gap sets the idle cycles before the next step
	task automatic step(input bit fwd, input int gap);
		phase_step = fwd ? phase_step + 1 : phase_step - 1;
		@(posedge i_core_clk);
		o_phase_a <= (phase_step & 3) inside {1, 2};
		o_phase_b <= (phase_step & 3) >= 2;
		repeat (gap) @(posedge i_core_clk);
	endtask

	// Edge on one phase only, as when the other wire is broken
	task automatic toggle(input bit on_b);
		@(posedge i_core_clk);
		if (on_b)
			o_phase_b <= ~o_phase_b;
		else
			o_phase_a <= ~o_phase_a;
		repeat (60) @(posedge i_core_clk);
	endtask

	// Once-per-turn marker, long enough to pass the input filter
	task automatic mark();
		@(posedge i_core_clk);
		o_index <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		o_index <= 1'b0;
		repeat (8) @(posedge i_core_clk);
	endtask
endmodule // enc_src_model

// ===== testbench/incremental_encoder_card_logic_tb_top.sv
`timescale 1ns/100ps

module incremental_encoder_card_logic_tb_top;
	import enc_card_pkg::*;
	// ==========================================================
	// Signals
	logic        i_core_clk, i_srst, i_board_power, i_wr, i_rd;
	logic        ea, eb, ez, ra, rb, rz;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, rd_val;
	logic        o_irq, o_div_out_a, o_div_out_b, o_div_out_index;
	logic        o_link_state_led, o_wire_break_led, o_power_led;
	int          err_total, samples_checked, div_steps, lit;
	logic [1:0]  div_prev;

	// Short blink so a full period fits in a few cycles
	enc_card_top #(.BLINK_HALF_CYC(8)) DUT (
		.i_core_clk(i_core_clk), .i_srst(i_srst), .i_enc_phase_a(ea), .i_enc_phase_b(eb),
		.i_enc_index(ez), .i_ref_phase_a(ra), .i_ref_phase_b(rb), .i_ref_index(rz),
		.i_board_power(i_board_power), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_div_out_a(o_div_out_a),
		.o_div_out_b(o_div_out_b), .o_div_out_index(o_div_out_index),
		.o_link_state_led(o_link_state_led), .o_wire_break_led(o_wire_break_led),
		.o_power_led(o_power_led));
	enc_src_model enc (.i_core_clk(i_core_clk), .o_phase_a(ea), .o_phase_b(eb), .o_index(ez));
	// Reference source uses the same line type as the encoder
	enc_src_model refs (.i_core_clk(i_core_clk), .o_phase_a(ra), .o_phase_b(rb), .o_index(rz));

	// ==========================================================
	// Clock and divided-output step counter
	always #12.5 i_core_clk = ~i_core_clk;

	// Any change of the divided pair is one output step
	always @(posedge i_core_clk) begin
		if ({o_div_out_a, o_div_out_b} !== div_prev)
			div_steps = div_steps + 1;
		div_prev = {o_div_out_a, o_div_out_b};
	end

	// ==========================================================
	// Bus and checking tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 rd_val = o_rdata;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Count lit cycles of the link or wire indicator, as selected, over two blink periods
	task automatic count_lit(input bit wire_led);
		lit = 0;
		repeat (32) begin
			@(posedge i_core_clk);
			lit += wire_led ? o_wire_break_led : o_link_state_led;
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rd(8'h0c);
		chk("ratio after reset", rd_val, 32'h1);
		rd(8'h20);
		chk("unmapped read", rd_val, 32'h0);
		wr(8'h04, 32'hff);
		rd(8'h0c);
		chk("ratio 255", rd_val, 32'hff);
		wr(8'h08, 32'h0);
		rd(8'h0c);
		chk("ratio zero", rd_val, 32'h1);
		$display("test regs done");
	endtask

	task automatic t_link();
		wr(8'h00, 32'h1);
		repeat (3) @(posedge i_core_clk);
		count_lit(1'b0);
		chk("link establishing", lit, 32);
		wr(8'h00, 32'h3);
		repeat (3) @(posedge i_core_clk);
		count_lit(1'b0);
		chk("link blink", lit, 16);
		wr(8'h00, 32'h0);
		repeat (3) @(posedge i_core_clk);
		count_lit(1'b0);
		chk("link off", lit, 0);
		i_board_power <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		chk("power on", o_power_led, 1'b1);
		i_board_power <= 1'b0;
		repeat (6) @(posedge i_core_clk);
		chk("power off", o_power_led, 1'b0);
		i_board_power <= 1'b1;
		$display("test link done");
	endtask

	task automatic t_quad();
		int d0;
		d0 = div_steps;
		repeat (4) enc.step(1'b1, 60);
		repeat (2) enc.step(1'b0, 60);
		repeat (3) refs.step(1'b1, 60);
		rd(8'h18);
		chk("enc position", rd_val, 32'h2);
		rd(8'h1c);
		chk("ref position", rd_val, 32'h3);
		chk("div steps ratio 1", div_steps - d0, 6);
		// Net two steps up from reset leaves the Gray pair at a=1, b=1
		chk("div phases", {30'h0, o_div_out_a, o_div_out_b}, 32'h3);
		wr(8'h14, 32'h1);
		fork
			enc.mark();
			begin
				// Three sync stages, filter and output register: look well inside the pulse
				repeat (8) @(posedge i_core_clk);
				chk("div index", o_div_out_index, 1'b1);
			end
		join
		chk("irq raised", o_irq, 1'b1);
		wr(8'h14, 32'h0);
		@(posedge i_core_clk);
		chk("irq masked", o_irq, 1'b0);
		wr(8'h14, 32'h1);
		wr(8'h10, 32'hf);
		@(posedge i_core_clk);
		chk("irq cleared", o_irq, 1'b0);
		$display("test quad done");
	endtask

	task automatic t_div();
		int d0;
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h2);
		rd(8'h0c);
		chk("last written ratio", rd_val, 32'h2);
		d0 = div_steps;
		repeat (6) enc.step(1'b1, 60);
		chk("div steps ratio 2", div_steps - d0, 3);
		$display("test div done");
	endtask

	// Step spacing 30 is over the 200 kHz rating but within 400 kHz
	task automatic t_speed();
		logic [3:0] var_tbl [3] = '{4'h0, 4'h4, 4'hc};
		for (int v = 0; v < 3; v++) begin
			wr(8'h00, {28'h0, var_tbl[v]});
			wr(8'h10, 32'hf);
			repeat (4) enc.step(1'b1, 30);
			rd(8'h10);
			chk("overspeed", rd_val[3], v != 2);
		end
		$display("test speed done");
	endtask

	task automatic t_wire();
		wr(8'h00, 32'h4);
		repeat (3) enc.toggle(1'b0);
		chk("simple lost", o_wire_break_led, 1'b0);
		enc.toggle(1'b1);
		chk("simple normal", o_wire_break_led, 1'b1);
		wr(8'h00, 32'h0);
		repeat (3) enc.toggle(1'b0);
		count_lit(1'b1);
		chk("full lost blinks", lit > 0 && lit < 32, 1'b1);
		enc.toggle(1'b1);
		chk("full normal", o_wire_break_led, 1'b1);
		rd(8'h10);
		chk("wire break status", rd_val[2], 1'b1);
		$display("test wire done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{i_core_clk, i_board_power, i_wr, i_rd, div_steps} = '0;
		{i_addr, i_wdata, err_total, samples_checked, div_prev} = '0;
		i_srst = 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_srst <= 1'b0;
		t_regs();
		t_link();
		t_quad();
		t_div();
		t_speed();
		t_wire();
		results();
	end

	// Whole run takes a few thousand cycles; 20000 means a hang
	initial begin
		#(20000 * 25);
		err_total++;
		results();
	end
endmodule // incremental_encoder_card_logic_tb_top
